// ### design/pts_pkg.sv
// package for the 8-bit period timer: offsets, fields, reset values
// assumes byte-wide register port, offsets as printed
package pts_pkg;
  localparam int unsigned PTS_AW = 8;
  localparam logic [7:0] PTS_OFS_COUNT = 8'h11;
  localparam logic [7:0] PTS_OFS_CTRL = 8'h12;
  localparam logic [7:0] PTS_OFS_PERIOD = 8'h92;
  localparam logic [7:0] PTS_OFS_FLAG = 8'h0c;
  localparam logic [7:0] PTS_OFS_ENABLE = 8'h8c;
  localparam int unsigned PTS_PRE_LSB = 0;
  localparam int unsigned PTS_RUN_BIT = 2;
  localparam int unsigned PTS_POST_LSB = 3;
  localparam int unsigned PTS_FLAG_BIT = 1;
  localparam logic [7:0] PTS_CTRL_MASK = 8'h7f;
  localparam logic [7:0] PTS_RST_COUNT = 8'h00;
  localparam logic [7:0] PTS_RST_CTRL = 8'h00;
  localparam logic [7:0] PTS_RST_PERIOD = 8'hff;
  localparam logic [3:0] PTS_PRE_DIV4_TC = 4'h3;
  localparam logic [3:0] PTS_PRE_DIV16_TC = 4'hf;
  localparam int unsigned PTS_INSTR_DIV = 4;
endpackage : pts_pkg

// ### design/pts_timer.sv
// 8-bit period timer with prescaler, period match and postscaler
// assumes synchronous inputs, byte register port, one clock domain
`timescale 1ns/10ps
`default_nettype none
module pts_timer
  import pts_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic serial_shift_tick,
  output logic pwm_period_tick
);
  logic [7:0] count_ff, nxt_count;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [7:0] period_ff, nxt_period;
  logic [1:0] iclk_ff;
  logic [3:0] pre_ff, nxt_pre;
  logic [3:0] post_ff, nxt_post;
  logic flag_ff, nxt_flag;
  logic irq_en_ff;
  logic irq_ff;
  logic match_ff;
  logic [7:0] rdata_ff;

  wire wr_count = reg_wr && reg_addr == PTS_OFS_COUNT;
  wire wr_ctrl = reg_wr && reg_addr == PTS_OFS_CTRL;
  wire wr_period = reg_wr && reg_addr == PTS_OFS_PERIOD;
  wire wr_flag = reg_wr && reg_addr == PTS_OFS_FLAG;
  wire wr_enable = reg_wr && reg_addr == PTS_OFS_ENABLE;
  wire run = ctrl_ff[PTS_RUN_BIT];
  wire [1:0] pre_sel = ctrl_ff[PTS_PRE_LSB +: 2];
  wire [3:0] post_sel = ctrl_ff[PTS_POST_LSB +: 4];
  wire iclk_tick = run && iclk_ff == 2'(PTS_INSTR_DIV - 1);
  wire [3:0] pre_tc = pre_sel[1] ? PTS_PRE_DIV16_TC : (pre_sel[0] ? PTS_PRE_DIV4_TC : 4'h0);
  wire pre_done = pre_ff == pre_tc;
  wire inc = iclk_tick && pre_done;
  wire at_period = count_ff == period_ff;
  wire match = inc && at_period;
  wire post_done = post_ff == post_sel;
  wire flag_set = match && post_done;
  wire scaler_clr = wr_count || wr_ctrl;

  always_comb begin
    nxt_pre = pre_ff;
    nxt_post = post_ff;
    nxt_count = count_ff;
    if (iclk_tick) begin
      nxt_pre = pre_done ? 4'h0 : pre_ff + 4'h1;
    end
    if (inc) begin
      nxt_count = at_period ? PTS_RST_COUNT : count_ff + 8'h01;
    end
    if (match) begin
      nxt_post = post_done ? 4'h0 : post_ff + 4'h1;
    end
    if (scaler_clr) begin
      nxt_pre = 4'h0;
      nxt_post = 4'h0;
    end
    if (wr_count) begin
      nxt_count = reg_wdata;
    end
  end

  assign nxt_ctrl = wr_ctrl ? (reg_wdata & PTS_CTRL_MASK) : ctrl_ff;
  assign nxt_period = wr_period ? reg_wdata : period_ff;
  // set wins over a write-one clear
  assign nxt_flag = flag_set || (flag_ff && !(wr_flag && reg_wdata[PTS_FLAG_BIT]));
  wire [1:0] nxt_iclk = run ? iclk_ff + 2'h1 : iclk_ff;
  wire nxt_irq_en = wr_enable ? reg_wdata[PTS_FLAG_BIT] : irq_en_ff;
  // irq follows the flag and enable that the same edge stores
  wire nxt_irq = nxt_flag && nxt_irq_en;

  wire [7:0] rd_mux =
    reg_addr == PTS_OFS_COUNT ? count_ff :
    reg_addr == PTS_OFS_CTRL ? ctrl_ff :
    reg_addr == PTS_OFS_PERIOD ? period_ff :
    reg_addr == PTS_OFS_FLAG ? 8'(flag_ff) << PTS_FLAG_BIT :
    reg_addr == PTS_OFS_ENABLE ? 8'(irq_en_ff) << PTS_FLAG_BIT : 8'h00;

  // read data stands in the cycle after each reg_rd cycle, zero otherwise
  wire [7:0] nxt_rdata = reg_rd ? rd_mux : 8'h00;

  // software visible registers
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= PTS_RST_COUNT;
    end else if (ce) begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= PTS_RST_CTRL;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      period_ff <= PTS_RST_PERIOD;
    end else if (ce) begin
      period_ff <= nxt_period;
    end
  end

  // instruction clock phase, not touched by register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      iclk_ff <= 2'h0;
    end else if (ce) begin
      iclk_ff <= nxt_iclk;
    end
  end

  // scaler counters
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_ff <= 4'h0;
    end else if (ce) begin
      pre_ff <= nxt_pre;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      post_ff <= 4'h0;
    end else if (ce) begin
      post_ff <= nxt_post;
    end
  end

  // interrupt state
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (ce) begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_en_ff <= 1'b0;
    end else if (ce) begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= nxt_irq;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      match_ff <= 1'b0;
    end else if (ce) begin
      match_ff <= match;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign serial_shift_tick = match_ff;
  assign pwm_period_tick = match_ff;

  // checks on control and register behaviour
  AST_BIT7_ZERO: assert property (@(posedge clk) disable iff (rst) ctrl_ff[7] == 1'b0)
    else $error("control bit 7 set");

  AST_CTRL_KEEPS_COUNT: assert property (@(posedge clk) disable iff (rst)
    ce && wr_ctrl && !inc |=> count_ff == $past(count_ff))
    else $error("control write changed count");

  AST_SCALER_CLR: assert property (@(posedge clk) disable iff (rst)
    ce && scaler_clr |=> pre_ff == 4'h0 && post_ff == 4'h0)
    else $error("scalers not cleared");

  AST_WRAP: assert property (@(posedge clk) disable iff (rst)
    ce && match && !wr_count |=> count_ff == 8'h00 && match_ff)
    else $error("no wrap at period");

  AST_STOP_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && !run && !reg_wr |=> $stable(count_ff) && $stable(pre_ff) && $stable(post_ff))
    else $error("stopped timer moved");

  AST_NEVER_PAST: assert property (@(posedge clk) disable iff (rst)
    ce && !reg_wr && count_ff <= period_ff |=> count_ff <= period_ff)
    else $error("count passed period");

  AST_FLAG_SET: assert property (@(posedge clk) disable iff (rst)
    ce && flag_set |=> flag_ff)
    else $error("terminal count lost");

  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    irq == (flag_ff && irq_en_ff))
    else $error("irq mismatch");

  AST_DIV1_RATE: assert property (@(posedge clk) disable iff (rst)
    ce && inc && pre_sel == 2'b00 && !reg_wr |-> ##1 (ce && run && !reg_wr)[*3] ##1 ce && run |-> inc)
    else $error("div1 rate wrong");

  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(count_ff) && $stable(ctrl_ff) && $stable(period_ff) && $stable(iclk_ff) && $stable(flag_ff))
    else $error("state moved with enable low");

  AST_ICLK_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && !run |=> $stable(iclk_ff))
    else $error("phase moved while stopped");

  AST_ICLK_STEP: assert property (@(posedge clk) disable iff (rst)
    ce && run |=> iclk_ff == $past(iclk_ff) + 2'h1)
    else $error("phase did not advance");

  AST_PRE_BOUND: assert property (@(posedge clk) disable iff (rst)
    pre_ff <= pre_tc)
    else $error("prescaler past terminal");

  AST_PRE_STEP: assert property (@(posedge clk) disable iff (rst)
    ce && iclk_tick && !pre_done && !scaler_clr |=> pre_ff == $past(pre_ff) + 4'h1)
    else $error("prescaler did not advance");

  AST_POST_BOUND: assert property (@(posedge clk) disable iff (rst)
    post_ff <= post_sel)
    else $error("postscaler past terminal");

  AST_POST_STEP: assert property (@(posedge clk) disable iff (rst)
    ce && match && !post_done && !scaler_clr |=> post_ff == $past(post_ff) + 4'h1)
    else $error("postscaler did not advance");

  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
    ce && inc && !at_period && !wr_count |=> count_ff == $past(count_ff) + 8'h01)
    else $error("count did not advance");

  AST_COUNT_LOAD: assert property (@(posedge clk) disable iff (rst)
    ce && wr_count |=> count_ff == $past(reg_wdata))
    else $error("count write lost");

  AST_PERIOD_LOAD: assert property (@(posedge clk) disable iff (rst)
    ce && wr_period |=> period_ff == $past(reg_wdata))
    else $error("period write lost");

  AST_CTRL_LOAD: assert property (@(posedge clk) disable iff (rst)
    ce && wr_ctrl |=> ctrl_ff[6:0] == $past(reg_wdata[6:0]))
    else $error("control write lost");

  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (rst)
    ce && flag_ff && !wr_flag |=> flag_ff)
    else $error("flag dropped by itself");

  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (rst)
    ce && wr_flag && reg_wdata[PTS_FLAG_BIT] && !flag_set |=> !flag_ff)
    else $error("flag not cleared");

  AST_FLAG_QUIET: assert property (@(posedge clk) disable iff (rst)
    ce && !flag_ff && !flag_set |=> !flag_ff)
    else $error("flag set without terminal count");

  AST_TICK_FOLLOWS: assert property (@(posedge clk) disable iff (rst)
    ce |=> serial_shift_tick == $past(match))
    else $error("tick not one cycle after match");

  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    ce && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  AST_RDATA_COUNT: assert property (@(posedge clk) disable iff (rst)
    ce && reg_rd && reg_addr == PTS_OFS_COUNT |=> reg_rdata == $past(count_ff))
    else $error("count read wrong");
endmodule : pts_timer
`default_nettype wire

// ### tb/test_period_timer_8bit_pre_post_scaled.sv
// bench for the period timer: registers, match spacing, postscaler, irq
// assumes pts_timer with pts_pkg register map; ce pulsed low once
`timescale 1ns/10ps
`default_nettype none
module test_period_timer_8bit_pre_post_scaled;
  import pts_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, ce = 1;
  logic [7:0] a = 0, wd = 0, rdat, p;
  logic irq, sst, ppt;
  logic [3:0] q;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'hbcf3, n, k;
  always #50 clk = ~clk;
  pts_timer u_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat), .irq(irq), .serial_shift_tick(sst), .pwm_period_tick(ppt));
  task chk(input logic [15:0] g, e, input string m);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task wreg(input logic [7:0] ad, v);
    @(posedge clk);
    wr <= 1;
    a <= ad;
    wd <= v;
    @(posedge clk);
    wr <= 0;
  endtask : wreg
  task rreg(input logic [7:0] ad, e, input string m);
    @(posedge clk);
    rd <= 1;
    a <= ad;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdat, e, m);
  endtask : rreg
  // cycles up to and including the next period tick
  task wt;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (ppt !== 1'b1 && n < 5000);
  endtask : wt
  function int gap(input int pp, input int ss);
    return (pp + 1) * (ss == 0 ? 1 : ss == 1 ? 4 : 16) * PTS_INSTR_DIV;
  endfunction : gap
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 0;
    rreg(PTS_OFS_COUNT, PTS_RST_COUNT, "count reset");
    rreg(PTS_OFS_CTRL, PTS_RST_CTRL, "ctrl reset");
    rreg(PTS_OFS_PERIOD, PTS_RST_PERIOD, "period reset");
    rreg(8'h55, 8'h00, "unmapped");
    wreg(PTS_OFS_CTRL, 8'hfb);
    rreg(PTS_OFS_CTRL, 8'h7b, "ctrl top bit");
    for (k = 0; k < 4; k++) begin
      p = (k == 0) ? 8'h00 : 8'({$random(seed)} % 16);
      wreg(PTS_OFS_PERIOD, p);
      rreg(PTS_OFS_PERIOD, p, "period rw");
      // count may sit above the new period; restart it from zero
      wreg(PTS_OFS_COUNT, 8'h00);
      wreg(PTS_OFS_CTRL, {5'h00, 1'b1, 2'(k)});
      wt;
      wt;
      chk(16'(n), 16'(gap(p, k)), "match spacing");
      chk(16'(sst), 16'h1, "serial tick");
    end
    q = 4'($random(seed));
    wreg(PTS_OFS_CTRL, {1'b0, q, 3'b000});
    wreg(PTS_OFS_COUNT, 8'h00);
    wreg(PTS_OFS_PERIOD, 8'h03);
    wreg(PTS_OFS_FLAG, 8'h02);
    wreg(PTS_OFS_ENABLE, 8'h02);
    #1 chk(16'(irq), 16'h0, "irq idle");
    wreg(PTS_OFS_CTRL, {1'b0, q, 3'b100});
    k = 0;
    n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
      if (ppt === 1'b1) k++;
    end
    chk(16'(k), 16'(q) + 16'h1, "postscale count");
    rreg(PTS_OFS_FLAG, 8'h02, "flag set");
    wreg(PTS_OFS_ENABLE, 8'h00);
    @(posedge clk);
    #1 chk(16'(irq), 16'h0, "irq masked");
    wreg(PTS_OFS_CTRL, 8'h00);
    wreg(PTS_OFS_FLAG, 8'h02);
    rreg(PTS_OFS_FLAG, 8'h00, "flag cleared");
    wreg(PTS_OFS_COUNT, 8'h5a);
    repeat (40) @(posedge clk);
    rreg(PTS_OFS_COUNT, 8'h5a, "stopped hold");
    wreg(PTS_OFS_CTRL, 8'h02);
    rreg(PTS_OFS_COUNT, 8'h5a, "ctrl write keeps count");
    // nine edges with enable low stretch one period by nine cycles
    wreg(PTS_OFS_CTRL, 8'h04);
    wreg(PTS_OFS_COUNT, 8'h00);
    wt;
    @(posedge clk);
    ce <= 0;
    repeat (9) @(posedge clk);
    ce <= 1;
    wt;
    chk(16'(n), 16'(gap(3, 0) + 9 - 10), "enable freeze");
    // second reset while running
    repeat (9) @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rreg(PTS_OFS_COUNT, PTS_RST_COUNT, "count second reset");
    rreg(PTS_OFS_PERIOD, PTS_RST_PERIOD, "period second reset");
    rreg(PTS_OFS_CTRL, PTS_RST_CTRL, "ctrl second reset");
    rreg(PTS_OFS_FLAG, 8'h00, "flag second reset");
    end_sim;
  end
endmodule : test_period_timer_8bit_pre_post_scaled
`default_nettype wire
